// *** hw/opco_top.sv ***
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "opco_defines.svh"


module opco_top
    import opco_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic [17:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [17:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Clocks from timers and oscillators
    input  opco_clk_in_s     clk_in,
    // Output terminals
    output opco_pins_s       pins,
    // Prescaler source clocks
    output logic             prescaler0_source_clock,
    output logic             prescaler1_source_clock
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read and the write path.

    function automatic opco_sel_e reg_sel(input logic [17:0] addr);
        opco_sel_e s;
        s = OPCO_SEL_NONE;
        unique case (addr[17:2])
            `OPCO_IDX_CLK_CTRL: s = OPCO_SEL_CLK_CTRL;
            `OPCO_IDX_G0_FLOAT: s = OPCO_SEL_G0_FLOAT;
            `OPCO_IDX_G0_DATA:  s = OPCO_SEL_G0_DATA;
            `OPCO_IDX_G1_FLOAT: s = OPCO_SEL_G1_FLOAT;
            `OPCO_IDX_G1_DATA:  s = OPCO_SEL_G1_DATA;
            `OPCO_IDX_G2_FLOAT: s = OPCO_SEL_G2_FLOAT;
            `OPCO_IDX_G2_DATA:  s = OPCO_SEL_G2_DATA;
            `OPCO_IDX_TMR_CTRL: s = OPCO_SEL_TMR_CTRL;
            default:            s = OPCO_SEL_NONE;
        endcase
        return s;
    endfunction : reg_sel

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    logic             osc_clock_out_enable_q;
    logic [1:0]       osc_clock_rate_q;
    logic [3:0]       g0_float_q;
    logic [3:0]       g0_data_q;
    logic             group1_float_bit_q;
    logic [3:0]       g1_data_q;
    logic             group2_float_bit_q;
    logic [3:0]       g2_data_q;
    logic [3:0]       tmr_ctrl_q;

    // Bus state.
    logic             awready_q;
    logic             wready_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic [17:0]      awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             arready_q;
    logic             rvalid_q;
    logic [1:0]       rresp_q;
    logic [31:0]      rdata_q;

    opco_sel_e        wsel;
    opco_sel_e        rsel;
    logic             do_write;
    logic             wr_en;
    logic [31:0]      rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Write path: address and data are taken in either order, then the
    // write happens once both are held and the response goes out.

    assign wsel     = reg_sel(awaddr_q);
    assign do_write = !awready_q && !wready_q && !bvalid_q;
    // Only byte lane 0 holds register bits; other lanes are ignored.
    assign wr_en    = do_write && wstrb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            awaddr_q  <= '0;
        end else if (ce) begin
            if (awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= awaddr;
            end else if (bvalid_q && bready) begin
                awready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (ce) begin
            if (wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end else if (bvalid_q && bready) begin
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `OPCO_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (wsel == OPCO_SEL_NONE) ? `OPCO_RESP_SLVERR
                                                    : `OPCO_RESP_OKAY;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Only defined fields are stored, so unused positions drop writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_clock_out_enable_q <= 1'b0;
            osc_clock_rate_q       <= `OPCO_RST_RATE;
            g0_float_q             <= `OPCO_RST_FLOAT;
            g0_data_q              <= `OPCO_RST_DATA;
            group1_float_bit_q     <= 1'b0;
            g1_data_q              <= `OPCO_RST_DATA;
            group2_float_bit_q     <= 1'b0;
            g2_data_q              <= `OPCO_RST_DATA;
            tmr_ctrl_q             <= `OPCO_RST_CTRL;
        end else if (ce && wr_en) begin
            unique case (wsel)
                OPCO_SEL_CLK_CTRL: begin
                    osc_clock_out_enable_q <= wdata_q[`OPCO_CC_ENABLE];
                    osc_clock_rate_q       <=
                        wdata_q[`OPCO_CC_RATE_HI:`OPCO_CC_RATE_LO];
                end
                OPCO_SEL_G0_FLOAT: g0_float_q <= wdata_q[3:0];
                OPCO_SEL_G0_DATA:  g0_data_q  <= wdata_q[3:0];
                OPCO_SEL_G1_FLOAT: begin
                    group1_float_bit_q <= wdata_q[`OPCO_FLOAT_BIT];
                end
                OPCO_SEL_G1_DATA:  g1_data_q  <= wdata_q[3:0];
                OPCO_SEL_G2_FLOAT: begin
                    group2_float_bit_q <= wdata_q[`OPCO_FLOAT_BIT];
                end
                OPCO_SEL_G2_DATA:  g2_data_q  <= wdata_q[3:0];
                OPCO_SEL_TMR_CTRL: tmr_ctrl_q <= wdata_q[3:0];
                OPCO_SEL_NONE:     ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: one read at a time, data one cycle after the address.

    assign rsel = reg_sel(araddr);

    always_comb begin
        rd_word = '0;
        unique case (rsel)
            OPCO_SEL_CLK_CTRL: begin
                rd_word[`OPCO_CC_ENABLE] = osc_clock_out_enable_q;
                rd_word[`OPCO_CC_RATE_HI:`OPCO_CC_RATE_LO] =
                    osc_clock_rate_q;
            end
            OPCO_SEL_G0_FLOAT: rd_word[3:0] = g0_float_q;
            OPCO_SEL_G0_DATA:  rd_word[3:0] = g0_data_q;
            OPCO_SEL_G1_FLOAT: begin
                rd_word[`OPCO_FLOAT_BIT] = group1_float_bit_q;
            end
            OPCO_SEL_G1_DATA:  rd_word[3:0] = g1_data_q;
            OPCO_SEL_G2_FLOAT: begin
                rd_word[`OPCO_FLOAT_BIT] = group2_float_bit_q;
            end
            OPCO_SEL_G2_DATA:  rd_word[3:0] = g2_data_q;
            OPCO_SEL_TMR_CTRL: rd_word[3:0] = tmr_ctrl_q;
            OPCO_SEL_NONE:     rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `OPCO_RESP_OKAY;
            rdata_q   <= '0;
        end else if (ce) begin
            if (arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_word;
                rresp_q   <= (rsel == OPCO_SEL_NONE) ? `OPCO_RESP_SLVERR
                                                     : `OPCO_RESP_OKAY;
            end else if (rvalid_q && rready) begin
                arready_q <= 1'b1;
                rvalid_q  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock inputs arrive from other domains and are synchronised first.
    // Sampling at the system rate limits the usable input frequency to
    // well below half of it; the output edges carry a cycle of jitter.

    opco_clk_in_s clk_s;
    opco_div_s    div;
    logic         tmr_clk;
    logic         osc_clk;

    opco_sync #(.W(4)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       (clk_in),
        .q       (clk_s)
    );

    opco_clk_div u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .clk_in  (clk_s.low_speed_osc_clock),
        .div     (div)
    );

    assign tmr_clk = tmr_ctrl_q[`OPCO_TC_TIMER_CHANNEL_SELECT] ? clk_s.timer1
                                                : clk_s.timer0;

    always_comb begin
        osc_clk = div.div64;
        unique case (osc_clock_rate_q)
            `OPCO_RATE_HIGH:  osc_clk = clk_s.high_speed_osc_clock;
            `OPCO_RATE_LOW:   osc_clk = clk_s.low_speed_osc_clock;
            `OPCO_RATE_DIV8:  osc_clk = div.div8;
            `OPCO_RATE_DIV64: osc_clk = div.div64;
        endcase
    end

    logic ps0_q;
    logic ps1_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps0_q <= 1'b0;
            ps1_q <= 1'b0;
        end else if (ce) begin
            ps0_q <= tmr_ctrl_q[`OPCO_TC_PS0] ? clk_s.high_speed_osc_clock
                                              : clk_s.low_speed_osc_clock;
            ps1_q <= tmr_ctrl_q[`OPCO_TC_PS1] ? clk_s.high_speed_osc_clock
                                              : clk_s.low_speed_osc_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Terminal logic.

    logic [11:0] float_v;
    logic [11:0] level_v;
    opco_pins_s  pins_q;

    assign float_v = {{4{group2_float_bit_q}}, {4{group1_float_bit_q}},
                      g0_float_q};

    // The enable switches the clock in without resynchronising it, so
    // turning a clock on or off can leave a short pulse on the pin.
    always_comb begin
        level_v = {g2_data_q, g1_data_q, g0_data_q};
        if (tmr_ctrl_q[`OPCO_TC_ENABLE]) begin
            level_v[`OPCO_TMR_PIN] =
                g0_data_q[`OPCO_TMR_PIN] & tmr_clk;
        end
        if (osc_clock_out_enable_q) begin
            level_v[`OPCO_OSC_PIN] =
                g0_data_q[`OPCO_OSC_PIN] & osc_clk;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_q.level <= `OPCO_RST_PIN_LVL;
            pins_q.oe_n  <= `OPCO_RST_PIN_OE_N;
        end else if (ce) begin
            pins_q.level <= level_v;
            pins_q.oe_n  <= float_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign awready                 = awready_q;
    assign wready                  = wready_q;
    assign bvalid                  = bvalid_q;
    assign bresp                   = bresp_q;
    assign arready                 = arready_q;
    assign rvalid                  = rvalid_q;
    assign rresp                   = rresp_q;
    assign rdata                   = rdata_q;
    assign pins                    = pins_q;
    assign prescaler0_source_clock = ps0_q;
    assign prescaler1_source_clock = ps1_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence g1_float_set_s;
        do_write && ce && wstrb_q[0] && wsel == OPCO_SEL_G1_FLOAT &&
            wdata_q[0] ##1 ce;
    endsequence

    sequence g2_data_write_s;
        do_write && ce && wstrb_q[0] && wsel == OPCO_SEL_G2_DATA &&
            !group2_float_bit_q ##1 ce;
    endsequence

    reset_levels_a: assert property (!$past(aresetn) |->
        pins_q.level == 12'hfff && pins_q.oe_n == 12'h000)
        else $error("pins not high after reset");

    group1_float_a: assert property (g1_float_set_s |=>
        pins_q.oe_n[7:4] == 4'hf)
        else $error("group one did not float together");

    group2_data_a: assert property (g2_data_write_s |=>
        pins_q.level[11:8] == $past(wdata_q[3:0], 2) &&
        pins_q.oe_n[11:8] == 4'h0)
        else $error("group two level does not follow data");

    data_readback_a: assert property (
        arvalid && arready_q && ce && rsel == OPCO_SEL_G0_DATA |=>
        rvalid_q && rdata_q == {28'h0, $past(g0_data_q)})
        else $error("group zero data read back wrong");

    unused_zero_a: assert property (
        arvalid && arready_q && ce && rsel == OPCO_SEL_CLK_CTRL |=>
        rdata_q[31:4] == 28'h0 && !rdata_q[2])
        else $error("unused bits read nonzero");

    osc_low_a: assert property ($past(ce) &&
        $past(osc_clock_out_enable_q && !g0_data_q[3] && !g0_float_q[3])
        |-> !pins_q.level[3] && !pins_q.oe_n[3])
        else $error("oscillator pin not held low");

    float_wins_a: assert property ($past(ce) &&
        $past(tmr_ctrl_q[2] && g0_float_q[2]) |-> pins_q.oe_n[2])
        else $error("timer pin drives while floated");

    timer_off_a: assert property ($past(ce) &&
        $past(!tmr_ctrl_q[2] && g0_data_q[2] && !g0_float_q[2])
        |-> pins_q.level[2])
        else $error("timer pin not high while off");

    timer_follow_a: assert property ($past(ce) &&
        $past(tmr_ctrl_q[2] && g0_data_q[2]) |->
        pins_q.level[2] == $past(tmr_ctrl_q[3] ? clk_s.timer1
                                               : clk_s.timer0))
        else $error("timer pin not following channel");

    osc_high_a: assert property ($past(ce) &&
        $past(osc_clock_out_enable_q && osc_clock_rate_q == 2'h3 &&
              g0_data_q[3]) |->
        pins_q.level[3] == $past(clk_s.high_speed_osc_clock))
        else $error("oscillator pin not at high rate");

    presc_sel_a: assert property ($past(ce) && $past(tmr_ctrl_q[0])
        |-> ps0_q == $past(clk_s.high_speed_osc_clock))
        else $error("prescaler zero source wrong");

    write_resp_a: assert property (do_write && ce |=>
        bvalid_q && (bresp_q == 2'h2) == ($past(wsel) == OPCO_SEL_NONE))
        else $error("write response missing or wrong");

endmodule : opco_top

// *** hw/opco_defines.svh ***
`ifndef OPCO_DEFINES_SVH
`define OPCO_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define OPCO_IDX_CLK_CTRL  16'hff06
`define OPCO_IDX_G0_FLOAT  16'hff30
`define OPCO_IDX_G0_DATA   16'hff31
`define OPCO_IDX_G1_FLOAT  16'hff32
`define OPCO_IDX_G1_DATA   16'hff33
`define OPCO_IDX_G2_FLOAT  16'hff34
`define OPCO_IDX_G2_DATA   16'hff35
`define OPCO_IDX_TMR_CTRL  16'hffc1

// Reset values.
`define OPCO_RST_DATA      4'hf
`define OPCO_RST_FLOAT     4'h0
`define OPCO_RST_CTRL      4'h0
`define OPCO_RST_RATE      2'h0
`define OPCO_RST_PIN_LVL   12'hfff
`define OPCO_RST_PIN_OE_N  12'h000

// Field positions.
`define OPCO_CC_ENABLE     3
`define OPCO_CC_RATE_HI    1
`define OPCO_CC_RATE_LO    0
`define OPCO_TC_TIMER_CHANNEL_SELECT      3
`define OPCO_TC_ENABLE     2
`define OPCO_TC_PS1        1
`define OPCO_TC_PS0        0
`define OPCO_FLOAT_BIT     0
`define OPCO_TMR_PIN       2
`define OPCO_OSC_PIN       3

// Oscillator clock rate codes.
`define OPCO_RATE_HIGH     2'h3
`define OPCO_RATE_LOW      2'h2
`define OPCO_RATE_DIV8     2'h1
`define OPCO_RATE_DIV64    2'h0

// Divider counter taps: bit k of a rising-edge counter divides by 2^(k+1).
`define OPCO_DIV_W         6
`define OPCO_DIV8_BIT      2
`define OPCO_DIV64_BIT     5

// Bus answers.
`define OPCO_RESP_OKAY     2'h0
`define OPCO_RESP_SLVERR   2'h2

`endif

// *** hw/opco_pkg.sv ***
package opco_pkg;

    typedef enum logic [3:0] {
        OPCO_SEL_NONE     = 4'h0,
        OPCO_SEL_CLK_CTRL = 4'h1,
        OPCO_SEL_G0_FLOAT = 4'h2,
        OPCO_SEL_G0_DATA  = 4'h3,
        OPCO_SEL_G1_FLOAT = 4'h4,
        OPCO_SEL_G1_DATA  = 4'h5,
        OPCO_SEL_G2_FLOAT = 4'h6,
        OPCO_SEL_G2_DATA  = 4'h7,
        OPCO_SEL_TMR_CTRL = 4'h8
    } opco_sel_e;

    typedef struct packed {
        logic timer0;
        logic timer1;
        logic low_speed_osc_clock;
        logic high_speed_osc_clock;
    } opco_clk_in_s;

    typedef struct packed {
        logic [11:0] level;
        logic [11:0] oe_n;
    } opco_pins_s;

    typedef struct packed {
        logic div8;
        logic div64;
    } opco_div_s;

endpackage : opco_pkg

// *** hw/opco_sync.sv ***
`timescale 1ns/1ps

module opco_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ff1_q <= '0;
            ff2_q <= '0;
        end else if (ce) begin
            ff1_q <= d;
            ff2_q <= ff1_q;
        end
    end

    assign q = ff2_q;

endmodule : opco_sync

// *** hw/opco_clk_div.sv ***
`timescale 1ns/1ps
`include "opco_defines.svh"

module opco_clk_div
    import opco_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // Synchronised low-speed clock level
    input  wire logic clk_in,
    // Divided clocks
    output opco_div_s div
);

    logic                   prev_q;
    logic [`OPCO_DIV_W-1:0] cnt_q;
    opco_div_s              div_q;

    // The counter steps on each rising edge seen in the system domain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
            cnt_q  <= '0;
        end else if (ce) begin
            prev_q <= clk_in;
            if (clk_in && !prev_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
        end else if (ce) begin
            div_q.div8  <= cnt_q[`OPCO_DIV8_BIT];
            div_q.div64 <= cnt_q[`OPCO_DIV64_BIT];
        end
    end

    assign div = div_q;

endmodule : opco_clk_div

// *** testbench/opco_load.sv ***
`timescale 1ns/1ps

// A floated line has no pull resistor, so it shows the inverse of its
// last driven level rather than a value the simulator might invent.
module opco_load
    import opco_pkg::*;
(
    // Clock
    input  wire logic   aclk,
    // Terminals
    input  opco_pins_s  pins,
    output logic [11:0] term
);
    logic [11:0] held_q;

    always_ff @(posedge aclk) begin
        for (int i = 0; i < 12; i++) begin
            if (!pins.oe_n[i]) held_q[i] <= pins.level[i];
        end
    end

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            term[i] = pins.oe_n[i] ? ~held_q[i] : pins.level[i];
        end
    end
endmodule : opco_load

// *** testbench/output_port_clock_out_tb.sv ***
`timescale 1ns/1ps
`include "opco_defines.svh"

module output_port_clock_out_tb import opco_pkg::*;;
    localparam logic [1:0] OK = `OPCO_RESP_OKAY;
    localparam logic [1:0] SE = `OPCO_RESP_SLVERR;
    logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid, ps0, ps1;
    logic [17:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb, mon;
    logic [1:0]   bresp, rresp;
    logic [11:0]  term;
    opco_clk_in_s clk_in;
    opco_pins_s   pins;
    int           n_fail = 0, checks = 0, cyc = 0;
    logic [15:0]  ix [8] = '{`OPCO_IDX_CLK_CTRL, `OPCO_IDX_G0_FLOAT,
        `OPCO_IDX_G0_DATA, `OPCO_IDX_G1_FLOAT, `OPCO_IDX_G1_DATA,
        `OPCO_IDX_G2_FLOAT, `OPCO_IDX_G2_DATA, `OPCO_IDX_TMR_CTRL};
    logic [3:0]   rv [8] = '{4'h0, 4'h0, 4'hf, 4'h0, 4'hf, 4'h0, 4'hf, 4'h0};
    logic [3:0]   wm [8] = '{4'hb, 4'hf, 4'hf, 4'h1, 4'hf, 4'h1, 4'hf, 4'hf};
    int           re [4] = '{2, 16, 128, 160};

    opco_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .clk_in(clk_in), .pins(pins), .prescaler0_source_clock(ps0),
        .prescaler1_source_clock(ps1));
    opco_load load (.aclk(aclk), .pins(pins), .term(term));
    assign mon = {ps1, ps0, term[3], term[2]};

    ////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 0;
        forever #2 aclk = ~aclk;
    end

    // Oscillator and timer periods 32, 40, 48 and 64 ns, off-phase.
    initial begin
        clk_in = '0;
        #1.3;
        fork
            forever #16 clk_in.high_speed_osc_clock = ~clk_in[0];
            forever #20 clk_in.low_speed_osc_clock = ~clk_in[1];
            forever #24 clk_in.timer0 = ~clk_in[3];
            forever #32 clk_in.timer1 = ~clk_in[2];
        join
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {a, 2'b00};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (1) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        chk("bresp", er, bresp);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= {a, 2'b00};
        arvalid <= 1;
        rready <= 1;
        while (1) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
    endtask : rd

    // Counts rises of one monitored line over 1280 cycles; zero is exact.
    task automatic cnt(input int s, input int e);
        int   n;
        logic p;
        n = 0;
        repeat (12) @(posedge aclk);
        p = mon[s];
        repeat (1280) begin
            @(posedge aclk);
            if (mon[s] && !p) n++;
            p = mon[s];
        end
        chk("rises", 1, e == 0 ? n == 0 : (n >= e - 1 && n <= e + 1));
    endtask : cnt

    ////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        chk("level", 12'hfff, pins.level);
        chk("oe_n", 0, pins.oe_n);
        for (int i = 0; i < 8; i++) rd(ix[i], rv[i], OK);
        for (int i = 0; i < 8; i++) begin
            wr(ix[i], 32'hffff_ffff, 4'hf, OK);
            rd(ix[i], wm[i], OK);
        end
        $display("test reset and masks done");
        for (int i = 0; i < 8; i++) wr(ix[i], rv[i], 4'hf, OK);
        wr(ix[2], 5, 4'hf, OK);
        wr(ix[4], 4'ha, 4'hf, OK);
        wr(ix[6], 3, 4'hf, OK);
        wr(16'h0001, 0, 4'hf, SE);
        rd(16'h0001, 0, SE);
        wr(ix[2], 4'hf, 4'he, OK);
        rd(ix[2], 5, OK);
        repeat (3) @(posedge aclk);
        chk("term", 12'h3a5, term);
        wr(ix[1], 4'ha, 4'hf, OK);
        wr(ix[3], 1, 4'hf, OK);
        repeat (3) @(posedge aclk);
        chk("oe_n", 12'h0fa, pins.oe_n);
        for (int i = 1; i < 7; i++) wr(ix[i], rv[i], 4'hf, OK);
        $display("test dc output done");
        for (int r = 0; r < 4; r++) begin
            wr(ix[0], 8 + r, 4'hf, OK);
            cnt(1, re[r]);
        end
        wr(ix[2], 4'h7, 4'hf, OK);
        cnt(1, 0);
        chk("osc low", 0, term[3]);
        wr(ix[2], 4'hf, 4'hf, OK);
        wr(ix[1], 8, 4'hf, OK);
        repeat (3) @(posedge aclk);
        chk("osc float", 1, pins.oe_n[3]);
        wr(ix[1], 0, 4'hf, OK);
        wr(ix[0], 3, 4'hf, OK);
        cnt(1, 0);
        chk("osc off", 1, term[3]);
        $display("test oscillator output done");
        wr(ix[7], 4'h4, 4'hf, OK);
        cnt(0, 106);
        wr(ix[7], 4'hc, 4'hf, OK);
        cnt(0, 80);
        wr(ix[7], 0, 4'hf, OK);
        cnt(0, 0);
        chk("tmr off", 1, term[2]);
        $display("test timer output done");
        wr(ix[7], 1, 4'hf, OK);
        cnt(2, 160);
        cnt(3, 128);
        wr(ix[7], 2, 4'hf, OK);
        cnt(2, 128);
        cnt(3, 160);
        $display("test prescaler source done");
        close_out();
    end
endmodule : output_port_clock_out_tb
